/* src/cpu_registers_and_condition_flags.sv */
// core register set, program counter and condition flag register
// Function
// - one 8-bit accumulator feeds ALU operands and takes results
// - two 8-bit index registers for addresses or temporary data
// - interrupt context save and restore never touch the second index register
// - 16-bit instruction pointer, low and high bytes loadable separately
// - core registers have no memory address, only instructions reach them
// - flag layout 1,1,upper mask,H,lower mask,N,Z,C; reset 111x1xxx
// - flags restorable by pop, readable for push, bits testable and alterable
// - add and add-with-carry set H on carry from bit 3, else clear it
// - branches on nibble carry set and clear
// - after result-producing ops N equals result bit 7
// - branches on sign set and clear
// - after result-producing ops Z is one exactly when result is zero
// - branches on result empty and nonempty
// - C set on overflow or borrow of arithmetic, cleared otherwise
// - instructions force C to one or zero; branches on C set and clear
// - bit test, shift and rotate also update C
// - mask pair encodes priority: 10=0, 01=1, 00=2, 11=3 disables
// - interrupt entry loads mask pair from its priority; software ops change it too
`timescale 1ns/100ps
`default_nettype none
module cpu_registers_and_condition_flags (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire cpu_core_pkg::op_t i_op,
    input wire cpu_core_pkg::ctx_t i_ctx,
    output logic [7:0] o_acc,
    output logic [7:0] o_idx_x,
    output logic [7:0] o_idx_y,
    output logic [15:0] o_instruction_pointer,
    output logic [7:0] o_flag_register,
    output logic o_branch_taken,
    output cpu_core_pkg::ctx_t o_ctx_save
);
    logic [7:0] acc_reg, acc_next;
    logic [7:0] idx_x_reg, idx_x_next;
    logic [7:0] idx_y_reg, idx_y_next;
    logic [15:0] ip_reg, ip_next;
    logic [7:0] flags_reg, flags_next;
    logic taken_reg, taken_next;
    cpu_core_pkg::ctx_t ctx_reg, ctx_next;
    logic [7:0] alu_a;
    logic [7:0] alu_res;
    logic alu_c, alu_h, alu_upd_c, alu_upd_h;
    logic cond_true;
    logic nz_upd;
    logic [7:0] nz_val;

    // the ALU always takes the accumulator as its first operand
    assign alu_a = acc_reg;

    flag_alu u_alu (
        .i_code(i_op.code),
        .i_a(alu_a),
        .i_b(i_op.data),
        .i_carry(flags_reg[cpu_core_pkg::FLAG_C]),
        .o_result(alu_res),
        .o_carry(alu_c),
        .o_half(alu_h),
        .o_upd_carry(alu_upd_c),
        .o_upd_half(alu_upd_h)
    );

    always_comb begin
        unique case (i_op.cond)
            cpu_core_pkg::BR_NIBBLE_CARRY: cond_true = flags_reg[cpu_core_pkg::FLAG_H];
            cpu_core_pkg::BR_NO_NIBBLE_CARRY: cond_true = !flags_reg[cpu_core_pkg::FLAG_H];
            cpu_core_pkg::BR_SIGN_SET: cond_true = flags_reg[cpu_core_pkg::FLAG_N];
            cpu_core_pkg::BR_SIGN_CLEAR: cond_true = !flags_reg[cpu_core_pkg::FLAG_N];
            cpu_core_pkg::BR_RESULT_EMPTY: cond_true = flags_reg[cpu_core_pkg::FLAG_Z];
            cpu_core_pkg::BR_RESULT_NONEMPTY: cond_true = !flags_reg[cpu_core_pkg::FLAG_Z];
            cpu_core_pkg::BR_OVERFLOW_SET: cond_true = flags_reg[cpu_core_pkg::FLAG_C];
            cpu_core_pkg::BR_OVERFLOW_CLEAR: cond_true = !flags_reg[cpu_core_pkg::FLAG_C];
            cpu_core_pkg::BR_ALWAYS: cond_true = 1'b1;
            default: cond_true = 1'b0;
        endcase
    end

    // next state of the architectural registers
    always_comb begin
        acc_next = acc_reg;
        idx_x_next = idx_x_reg;
        idx_y_next = idx_y_reg;
        ip_next = ip_reg;
        flags_next = flags_reg;
        taken_next = 1'b0;
        ctx_next = ctx_reg;
        nz_upd = 1'b0;
        nz_val = 8'h00;
        if (i_op.valid) begin
            ip_next = ip_reg + 16'h0001;
            unique case (i_op.code)
                cpu_core_pkg::OP_LD_A: begin
                    acc_next = i_op.data;
                    nz_upd = 1'b1;
                    nz_val = i_op.data;
                end
                cpu_core_pkg::OP_LD_X: begin
                    idx_x_next = i_op.data;
                    nz_upd = 1'b1;
                    nz_val = i_op.data;
                end
                cpu_core_pkg::OP_LD_Y: begin
                    idx_y_next = i_op.data;
                    nz_upd = 1'b1;
                    nz_val = i_op.data;
                end
                cpu_core_pkg::OP_LD_IPL: ip_next = {ip_reg[15:8], i_op.data};
                cpu_core_pkg::OP_LD_IPH: ip_next = {i_op.data, ip_reg[7:0]};
                cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC, cpu_core_pkg::OP_SUB,
                cpu_core_pkg::OP_SBC, cpu_core_pkg::OP_AND, cpu_core_pkg::OP_OR,
                cpu_core_pkg::OP_XOR, cpu_core_pkg::OP_INC, cpu_core_pkg::OP_DEC,
                cpu_core_pkg::OP_SHL, cpu_core_pkg::OP_SHR, cpu_core_pkg::OP_ROL,
                cpu_core_pkg::OP_ROR: begin
                    acc_next = alu_res;
                    nz_upd = 1'b1;
                    nz_val = alu_res;
                end
                cpu_core_pkg::OP_BTST: nz_upd = 1'b0;
                cpu_core_pkg::OP_SCF: flags_next[cpu_core_pkg::FLAG_C] = 1'b1;
                cpu_core_pkg::OP_RCF: flags_next[cpu_core_pkg::FLAG_C] = 1'b0;
                cpu_core_pkg::OP_SIM: begin
                    flags_next[cpu_core_pkg::FLAG_MASK_UPPER] = cpu_core_pkg::PRIO_LEVEL3[1];
                    flags_next[cpu_core_pkg::FLAG_MASK_LOWER] = cpu_core_pkg::PRIO_LEVEL3[0];
                end
                cpu_core_pkg::OP_RIM: begin
                    flags_next[cpu_core_pkg::FLAG_MASK_UPPER] = cpu_core_pkg::PRIO_LEVEL0[1];
                    flags_next[cpu_core_pkg::FLAG_MASK_LOWER] = cpu_core_pkg::PRIO_LEVEL0[0];
                end
                cpu_core_pkg::OP_POP_CC: flags_next = i_op.data;
                cpu_core_pkg::OP_BRANCH: begin
                    if (cond_true) begin
                        ip_next = ip_reg + 16'h0001 + {{8{i_op.data[7]}}, i_op.data};
                        taken_next = 1'b1;
                    end
                end
                cpu_core_pkg::OP_IRQ_ENTRY: begin
                    // save context, jump to the supplied vector, load the mask pair from the op priority
                    ctx_next = '{flags: flags_reg, acc: acc_reg, idx_x: idx_x_reg, ip: ip_reg};
                    ip_next = i_ctx.ip;
                    flags_next[cpu_core_pkg::FLAG_MASK_UPPER] = i_op.prio[1];
                    flags_next[cpu_core_pkg::FLAG_MASK_LOWER] = i_op.prio[0];
                end
                cpu_core_pkg::OP_IRET: begin
                    flags_next = i_ctx.flags;
                    acc_next = i_ctx.acc;
                    idx_x_next = i_ctx.idx_x;
                    ip_next = i_ctx.ip;
                end
                default: ip_next = ip_reg + 16'h0001;
            endcase
            if (alu_upd_c) begin
                flags_next[cpu_core_pkg::FLAG_C] = alu_c;
            end
            if (alu_upd_h) begin
                flags_next[cpu_core_pkg::FLAG_H] = alu_h;
            end
            if (nz_upd) begin
                flags_next[cpu_core_pkg::FLAG_N] = nz_val[7];
                flags_next[cpu_core_pkg::FLAG_Z] = (nz_val == 8'h00);
            end
        end
        flags_next[7:6] = cpu_core_pkg::FLAG_FIXED;
    end

    // registers live only here; nothing maps them into an address space
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            acc_reg <= cpu_core_pkg::DATA_RESET;
            idx_x_reg <= cpu_core_pkg::DATA_RESET;
            idx_y_reg <= cpu_core_pkg::DATA_RESET;
            ip_reg <= cpu_core_pkg::IP_RESET;
            flags_reg <= cpu_core_pkg::FLAGS_RESET;
            taken_reg <= 1'b0;
            ctx_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            idx_x_reg <= idx_x_next;
            idx_y_reg <= idx_y_next;
            ip_reg <= ip_next;
            flags_reg <= flags_next;
            taken_reg <= taken_next;
            ctx_reg <= ctx_next;
        end
    end

    assign o_acc = acc_reg;
    assign o_idx_x = idx_x_reg;
    assign o_idx_y = idx_y_reg;
    assign o_instruction_pointer = ip_reg;
    assign o_flag_register = flags_reg;
    assign o_branch_taken = taken_reg;
    assign o_ctx_save = ctx_reg;

    // helper for the half-carry check
    logic [4:0] half_ref;
    assign half_ref = {1'b0, acc_reg[3:0]} + {1'b0, i_op.data[3:0]}
        + {4'h0, i_op.code == cpu_core_pkg::OP_ADC && flags_reg[cpu_core_pkg::FLAG_C]};

    property p_fixed_ones;
        @(posedge i_clk_sys) disable iff (i_rst) o_flag_register[7:6] == 2'h3;
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fixed flag bits not one");

    property p_reset_flags;
        @(posedge i_clk_sys) $fell(i_rst) |-> o_flag_register == 8'he8 || $past(i_op.valid);
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flag reset value wrong");

    property p_half;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && (i_op.code == cpu_core_pkg::OP_ADD || i_op.code == cpu_core_pkg::OP_ADC)
            |=> o_flag_register[4] == $past(half_ref[4]);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong after add");

    property p_sign;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_SUB,
                cpu_core_pkg::OP_AND, cpu_core_pkg::OP_XOR, cpu_core_pkg::OP_LD_A, cpu_core_pkg::OP_INC}
            |=> o_flag_register[2] == o_acc[7];
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag does not copy result bit 7");

    property p_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_SUB,
                cpu_core_pkg::OP_OR, cpu_core_pkg::OP_LD_A, cpu_core_pkg::OP_DEC}
            |=> o_flag_register[1] == (o_acc == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sub_borrow;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_SUB
            |=> o_flag_register[0] == ($past(o_acc) < $past(i_op.data));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

    property p_force_carry;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && (i_op.code == cpu_core_pkg::OP_SCF || i_op.code == cpu_core_pkg::OP_RCF)
            |=> o_flag_register[0] == ($past(i_op.code) == cpu_core_pkg::OP_SCF)
                && $stable(o_acc);
    endproperty
    a_force_carry: assert property (p_force_carry) else $error("carry force failed");

    property p_shift_carry;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_SHL |=> o_flag_register[0] == $past(o_acc[7]);
    endproperty
    a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

    property p_y_irq;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && (i_op.code == cpu_core_pkg::OP_IRQ_ENTRY || i_op.code == cpu_core_pkg::OP_IRET)
            |=> $stable(o_idx_y);
    endproperty
    a_y_irq: assert property (p_y_irq) else $error("second index changed by interrupt");

    property p_irq_mask;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_IRQ_ENTRY
            |=> {o_flag_register[5], o_flag_register[3]} == $past(i_op.prio)
                && o_ctx_save.ip == $past(o_instruction_pointer);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("mask pair not loaded on entry");

    property p_branch_h;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_BRANCH && i_op.cond == cpu_core_pkg::BR_NIBBLE_CARRY
            |=> o_branch_taken == $past(o_flag_register[4]);
    endproperty
    a_branch_h: assert property (p_branch_h) else $error("nibble carry branch wrong");

    property p_branch_z;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_BRANCH && i_op.cond == cpu_core_pkg::BR_RESULT_EMPTY
            |=> o_branch_taken == $past(o_flag_register[1]);
    endproperty
    a_branch_z: assert property (p_branch_z) else $error("result empty branch wrong");

    property p_mask_sw;
        @(posedge i_clk_sys) disable iff (i_rst) i_op.valid && i_op.code == cpu_core_pkg::OP_SIM
            |=> {o_flag_register[5], o_flag_register[3]} == cpu_core_pkg::PRIO_LEVEL3;
    endproperty
    a_mask_sw: assert property (p_mask_sw) else $error("mask pair not raised");

    property p_ip_low;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_op.valid && i_op.code == cpu_core_pkg::OP_LD_IPL
            |=> o_instruction_pointer == {$past(o_instruction_pointer[15:8]), $past(i_op.data)};
    endproperty
    a_ip_low: assert property (p_ip_low) else $error("low pointer byte load wrong");

    c_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_op.valid && i_op.code == cpu_core_pkg::OP_IRQ_ENTRY ##1 i_op.valid && i_op.code == cpu_core_pkg::OP_IRET);
    c_taken: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_branch_taken);
    c_half: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_flag_register[4]));
    c_borrow: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_flag_register[0]));
endmodule
`default_nettype wire

/* src/cpu_core_pkg.sv */
// shared types and constants for the core register set and flag logic
package cpu_core_pkg;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_MASK_LOWER = 3;
    localparam int FLAG_H = 4;
    localparam int FLAG_MASK_UPPER = 5;
    localparam logic [1:0] FLAG_FIXED = 2'h3;
    // reset value 111x1xxx with unknown bits taken as zero
    localparam logic [7:0] FLAGS_RESET = 8'he8;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] IP_RESET = 16'h0000;
    // {upper, lower} mask pairs per software priority level
    localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
    localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
    localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
    localparam logic [1:0] PRIO_LEVEL3 = 2'h3;

    typedef enum logic [4:0] {
        OP_NOP, OP_LD_A, OP_LD_X, OP_LD_Y, OP_LD_IPL, OP_LD_IPH,
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
        OP_INC, OP_DEC, OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_BTST,
        OP_SCF, OP_RCF, OP_SIM, OP_RIM, OP_POP_CC, OP_BRANCH,
        OP_IRQ_ENTRY, OP_IRET
    } op_code_t;

    typedef enum logic [3:0] {
        BR_ALWAYS, BR_NIBBLE_CARRY, BR_NO_NIBBLE_CARRY, BR_SIGN_SET, BR_SIGN_CLEAR,
        BR_RESULT_EMPTY, BR_RESULT_NONEMPTY, BR_OVERFLOW_SET, BR_OVERFLOW_CLEAR
    } branch_cond_t;

    typedef struct packed {
        logic valid;
        op_code_t code;
        branch_cond_t cond;
        logic [7:0] data;
        logic [1:0] prio;
    } op_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] acc;
        logic [7:0] idx_x;
        logic [15:0] ip;
    } ctx_t;
endpackage

/* src/flag_alu.sv */
// combinational result and carry/half-carry logic for one instruction
`timescale 1ns/100ps
`default_nettype none
module flag_alu (
    input wire cpu_core_pkg::op_code_t i_code,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_carry,
    output logic [7:0] o_result,
    output logic o_carry,
    output logic o_half,
    output logic o_upd_carry,
    output logic o_upd_half
);
    logic [8:0] sum;
    logic [4:0] nib;

    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        o_result = i_a;
        o_carry = i_carry;
        o_half = 1'b0;
        o_upd_carry = 1'b0;
        o_upd_half = 1'b0;
        unique case (i_code)
            cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_code == cpu_core_pkg::OP_ADC && i_carry};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_code == cpu_core_pkg::OP_ADC && i_carry};
                o_result = sum[7:0];
                o_carry = sum[8];
                o_half = nib[4];
                o_upd_carry = 1'b1;
                o_upd_half = 1'b1;
            end
            cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC: begin
                sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_code == cpu_core_pkg::OP_SBC && i_carry};
                o_result = sum[7:0];
                o_carry = sum[8];
                o_upd_carry = 1'b1;
            end
            cpu_core_pkg::OP_AND: o_result = i_a & i_b;
            cpu_core_pkg::OP_OR: o_result = i_a | i_b;
            cpu_core_pkg::OP_XOR: o_result = i_a ^ i_b;
            cpu_core_pkg::OP_INC: o_result = i_a + 8'h01;
            cpu_core_pkg::OP_DEC: o_result = i_a - 8'h01;
            cpu_core_pkg::OP_SHL, cpu_core_pkg::OP_ROL: begin
                o_result = {i_a[6:0], i_code == cpu_core_pkg::OP_ROL && i_carry};
                o_carry = i_a[7];
                o_upd_carry = 1'b1;
            end
            cpu_core_pkg::OP_SHR, cpu_core_pkg::OP_ROR: begin
                o_result = {i_code == cpu_core_pkg::OP_ROR && i_carry, i_a[7:1]};
                o_carry = i_a[0];
                o_upd_carry = 1'b1;
            end
            cpu_core_pkg::OP_BTST: begin
                o_carry = i_a[i_b[2:0]];
                o_upd_carry = 1'b1;
            end
            default: o_result = i_a;
        endcase
    end
endmodule
`default_nettype wire

/* dv/cpu_registers_and_condition_flags_tb.sv */
// self-checking bench for the core register set and condition flags
`timescale 1ns/100ps
`default_nettype none
module cpu_registers_and_condition_flags_tb;
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] x;
        logic [7:0] y;
        logic [15:0] ip;
        logic [7:0] flags;
        logic taken;
        cpu_core_pkg::ctx_t ctx;
        logic chkf;
    } note_t;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    cpu_core_pkg::op_t i_op = '0;
    cpu_core_pkg::ctx_t i_ctx = '0;
    logic [7:0] o_acc, o_idx_x, o_idx_y, o_flag_register;
    logic [15:0] o_instruction_pointer;
    logic o_branch_taken;
    cpu_core_pkg::ctx_t o_ctx_save;
    note_t m;
    note_t n;
    note_t q[$];
    logic took;
    logic [31:0] seed = 32'h7590;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    cpu_core_pkg::op_code_t ac [23] = '{cpu_core_pkg::OP_LD_A, cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADD,
        cpu_core_pkg::OP_ADC, cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC, cpu_core_pkg::OP_LD_A,
        cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_AND, cpu_core_pkg::OP_OR, cpu_core_pkg::OP_XOR,
        cpu_core_pkg::OP_INC, cpu_core_pkg::OP_DEC, cpu_core_pkg::OP_SCF, cpu_core_pkg::OP_ROL,
        cpu_core_pkg::OP_RCF, cpu_core_pkg::OP_ROR, cpu_core_pkg::OP_SHL, cpu_core_pkg::OP_SHR,
        cpu_core_pkg::OP_BTST, cpu_core_pkg::OP_BTST, cpu_core_pkg::OP_DEC, cpu_core_pkg::OP_INC};
    logic [7:0] ad [23] = '{8'h08, 8'h08, 8'hf8, 8'h07, 8'h11, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hf0, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    logic [1:0] pl [4] = '{cpu_core_pkg::PRIO_LEVEL0, cpu_core_pkg::PRIO_LEVEL1, cpu_core_pkg::PRIO_LEVEL2,
        cpu_core_pkg::PRIO_LEVEL3};

    cpu_registers_and_condition_flags dut_u (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_op(i_op),
        .i_ctx(i_ctx),
        .o_acc(o_acc),
        .o_idx_x(o_idx_x),
        .o_idx_y(o_idx_y),
        .o_instruction_pointer(o_instruction_pointer),
        .o_flag_register(o_flag_register),
        .o_branch_taken(o_branch_taken),
        .o_ctx_save(o_ctx_save)
    );

    always #12.5 i_clk_sys = ~i_clk_sys;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // drive one instruction and note the state expected after it
    task automatic op(input cpu_core_pkg::op_code_t c, input logic [7:0] d,
                      input cpu_core_pkg::branch_cond_t bc = cpu_core_pkg::BR_ALWAYS,
                      input logic [1:0] pr = 2'h0, input cpu_core_pkg::ctx_t cx = '0);
        logic [8:0] r;
        logic [4:0] h;
        logic [8:0] tv;
        logic [15:0] ip0;
        logic nz, wa, wc, ci, cf;
        @(posedge i_clk_sys);
        #1;
        i_op <= '{1'b1, c, bc, d, pr};
        i_ctx <= cx;
        {nz, wa, wc} = 3'h0;
        r = 9'h000;
        cf = m.flags[0];
        ip0 = m.ip;
        m.ip = ip0 + 16'h0001;
        m.taken = 1'b0;
        m.chkf = 1'b1;
        case (c)
            cpu_core_pkg::OP_LD_A, cpu_core_pkg::OP_LD_X, cpu_core_pkg::OP_LD_Y: begin
                r = {1'b0, d};
                nz = 1'b1;
                wa = (c == cpu_core_pkg::OP_LD_A);
            end
            cpu_core_pkg::OP_LD_IPL: m.ip = {ip0[15:8], d};
            cpu_core_pkg::OP_LD_IPH: m.ip = {d, ip0[7:0]};
            cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC: begin
                ci = (c == cpu_core_pkg::OP_ADC) & cf;
                r = {1'b0, m.acc} + {1'b0, d} + {8'h00, ci};
                h = {1'b0, m.acc[3:0]} + {1'b0, d[3:0]} + {4'h0, ci};
                m.flags[4] = h[4];
                {nz, wa, wc} = 3'h7;
            end
            cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC: begin
                ci = (c == cpu_core_pkg::OP_SBC) & cf;
                r = {1'b0, m.acc} - {1'b0, d} - {8'h00, ci};
                {nz, wa, wc} = 3'h7;
            end
            cpu_core_pkg::OP_AND, cpu_core_pkg::OP_OR, cpu_core_pkg::OP_XOR,
            cpu_core_pkg::OP_INC, cpu_core_pkg::OP_DEC: begin
                r[7:0] = (c == cpu_core_pkg::OP_AND) ? (m.acc & d) : (c == cpu_core_pkg::OP_OR) ? (m.acc | d) :
                    (c == cpu_core_pkg::OP_XOR) ? (m.acc ^ d) : (c == cpu_core_pkg::OP_INC) ? (m.acc + 8'h01) :
                    (m.acc - 8'h01);
                {nz, wa} = 2'h3;
            end
            cpu_core_pkg::OP_SHL, cpu_core_pkg::OP_SHR, cpu_core_pkg::OP_ROL, cpu_core_pkg::OP_ROR: begin
                r = (c == cpu_core_pkg::OP_SHL) ? {m.acc, 1'b0} : (c == cpu_core_pkg::OP_ROL) ? {m.acc, cf} :
                    (c == cpu_core_pkg::OP_SHR) ? {m.acc[0], 1'b0, m.acc[7:1]} : {m.acc[0], cf, m.acc[7:1]};
                {nz, wa, wc} = 3'h7;
            end
            cpu_core_pkg::OP_BTST: m.flags[0] = m.acc[d[2:0]];
            cpu_core_pkg::OP_SCF, cpu_core_pkg::OP_RCF: m.flags[0] = (c == cpu_core_pkg::OP_SCF);
            cpu_core_pkg::OP_SIM, cpu_core_pkg::OP_RIM: begin
                m.flags[5] = 1'b1;
                m.flags[3] = (c == cpu_core_pkg::OP_SIM);
            end
            cpu_core_pkg::OP_POP_CC: m.flags = d | 8'hc0;
            cpu_core_pkg::OP_BRANCH: begin
                tv = {~cf, cf, ~m.flags[1], m.flags[1], ~m.flags[2], m.flags[2], ~m.flags[4], m.flags[4], 1'b1};
                m.taken = tv[bc];
                if (m.taken) m.ip = m.ip + {{8{d[7]}}, d};
            end
            cpu_core_pkg::OP_IRQ_ENTRY: begin
                m.ctx = {m.flags, m.acc, m.x, ip0};
                m.ip = cx.ip;
                m.flags[5] = pr[1];
                m.flags[3] = pr[0];
            end
            cpu_core_pkg::OP_IRET: begin
                m.flags = cx.flags | 8'hc0;
                m.acc = cx.acc;
                m.x = cx.idx_x;
                m.ip = cx.ip;
            end
            default: ;
        endcase
        if (nz) m.flags[2:1] = {r[7], r[7:0] == 8'h00};
        if (wc) m.flags[0] = r[8];
        if (wa) m.acc = r[7:0];
        if (c == cpu_core_pkg::OP_LD_X) m.x = d;
        if (c == cpu_core_pkg::OP_LD_Y) m.y = d;
        q.push_back(m);
    endtask

    task automatic done(input string name);
        @(posedge i_clk_sys);
        #1;
        i_op.valid <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        $display("test %s finished", name);
    endtask

    task automatic chk_reset();
        check(32'(o_acc), 32'h0);
        check(32'({o_idx_x, o_idx_y, o_instruction_pointer}), 32'h0);
        check(32'(o_flag_register), 32'(cpu_core_pkg::FLAGS_RESET));
        check(32'(o_branch_taken), 32'h0);
        check(o_ctx_save[39:8], 32'h0);
        check(32'(o_ctx_save[7:0]), 32'h0);
        m = '0;
        m.flags = cpu_core_pkg::FLAGS_RESET;
    endtask

    // result watcher: one note per accepted instruction
    always @(posedge i_clk_sys) begin
        took = i_op.valid & ~i_rst;
        #2;
        if (took === 1'b1) begin
            if (q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                n = q.pop_front();
                check(32'(o_acc), 32'(n.acc));
                check(32'(o_idx_x), 32'(n.x));
                check(32'(o_idx_y), 32'(n.y));
                check(32'(o_instruction_pointer), 32'(n.ip));
                if (n.chkf) check(32'(o_flag_register), 32'(n.flags));
                check(32'(o_branch_taken), 32'(n.taken));
                check(o_ctx_save[39:8], n.ctx[39:8]);
                check(32'(o_ctx_save[7:0]), 32'(n.ctx[7:0]));
            end
        end
    end

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        cpu_core_pkg::op_code_t c;
        m = '0;
        m.flags = cpu_core_pkg::FLAGS_RESET;
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        chk_reset();
        op(cpu_core_pkg::OP_LD_A, 8'h80);
        op(cpu_core_pkg::OP_LD_X, 8'h00);
        op(cpu_core_pkg::OP_LD_Y, 8'h5a);
        op(cpu_core_pkg::OP_LD_IPL, 8'h34);
        op(cpu_core_pkg::OP_LD_IPH, 8'h12);
        op(cpu_core_pkg::OP_POP_CC, 8'h00);
        done("loads");
        for (int k = 0; k < 23; k++) op(ac[k], ad[k]);
        done("arithmetic");
        for (int p = 0; p < 2; p++) begin
            op(cpu_core_pkg::OP_POP_CC, p[0] ? 8'h17 : 8'h00);
            for (int b = 0; b < 9; b++) op(cpu_core_pkg::OP_BRANCH, b[0] ? 8'hfe : 8'h05,
                                             cpu_core_pkg::branch_cond_t'(4'(b)));
        end
        done("branches");
        for (int p = 0; p < 4; p++) begin
            op(cpu_core_pkg::OP_IRQ_ENTRY, 8'h00, cpu_core_pkg::BR_ALWAYS, pl[p], 40'({rnd(), rnd()}));
            op(cpu_core_pkg::OP_IRET, 8'h00, cpu_core_pkg::BR_ALWAYS, 2'h0, 40'({rnd(), rnd()}));
        end
        op(cpu_core_pkg::OP_SIM, 8'h00);
        op(cpu_core_pkg::OP_RIM, 8'h00);
        done("interrupt context");
        for (int k = 0; k < 150; k++) begin
            c = cpu_core_pkg::op_code_t'(5'(rnd() % 28));
            if (c == cpu_core_pkg::OP_LD_IPL || c == cpu_core_pkg::OP_LD_IPH) c = cpu_core_pkg::OP_LD_A;
            op(c, 8'(rnd()), cpu_core_pkg::branch_cond_t'(4'(rnd() % 9)), 2'(rnd()), 40'({rnd(), rnd()}));
        end
        done("random");
        @(posedge i_clk_sys);
        #1;
        i_rst = 1'b1;
        #1;
        chk_reset();
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        op(cpu_core_pkg::OP_LD_A, 8'h81);
        op(cpu_core_pkg::OP_ADD, 8'h7f);
        done("second reset");
        check(32'(q.size()), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
